// ### dac_cmd_decoder.sv
// Octal DAC serial command decoder with APB status view
//
// Behaviour
// - Frame sync low for 16 falling clock edges; sample data each falling edge.
// - Decoded command executes only on frame sync rising after 15 or more falling edges.
// - Frame sync rising before 15th falling edge aborts and discards frame.
// - Chain out low 14 edges, high on 15th, then echoes input bits.
// - Reset selects register-only mode; data writes leave outputs unchanged.
// - Nibble 1001 selects write-through, 1000 register-only; mode persists.
// - Bit 15 zero: bits 14..12 select channel A..H register to load.
// - Write-through mode data write updates register and output code.
// - Channel code sits in bits 11..4; bits 3..0 ignored.
// - Special commands work in either mode and keep the mode.
// - Update-select copies register to output for each set bit 7..0.
// - Channel-A write loads A register and output, updates all others.
// - Channel-A write in register-only mode stays in register-only mode.
// - Broadcast writes one code, bits 11..4, to all registers and outputs.
// - Reset clears all registers and outputs to code zero.
// - Power-down affects channels whose bit 7..0 is set, others untouched.
// - Nibble 1101 high-Z, 1110 100k, 1111 2.5k termination.
// - Power-down never alters channel registers.
// - Bias enable drops only when all eight channels are powered down.
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module dac_cmd_decoder (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [11:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire dac_cmd_pkg::serial_in_t     ser_in,
    output logic                             chain_out,
    output logic [dac_cmd_pkg::NUM_CH*8-1:0] out_code,
    output logic [dac_cmd_pkg::NUM_CH-1:0]   pd_active,
    output dac_cmd_pkg::term_t               pd_term,
    output logic                             bias_en,
    output logic                             write_through_mode
);
    localparam int N = dac_cmd_pkg::NUM_CH;

    // Two-flop synchronisers for the serial pins
    // Reset to the idle pin levels so that no false clock edge follows reset
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic       sclk_prev_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q      <= 3'b110;
            sync_q      <= 3'b110;
            sclk_prev_q <= 1'b1;
        end else begin
            meta_q      <= {ser_in.sclk, ser_in.sync_n, ser_in.din};
            sync_q      <= meta_q;
            sclk_prev_q <= sync_q[2];
        end
    end

    wire sclk_s   = sync_q[2];
    wire sync_n_s = sync_q[1];
    wire din_s    = sync_q[0];
    wire fall     = sclk_prev_q & ~sclk_s;

    logic        sync_prev_q;
    logic [15:0] shift_q;
    logic [4:0]  edges_q;
    logic [14:0] echo_q;
    logic        chain_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) sync_prev_q <= 1'b1;
        else          sync_prev_q <= sync_n_s;
    end
    wire frame_end = sync_n_s & ~sync_prev_q;
    wire take_bit  = ~sync_n_s & fall;
    wire [4:0] edges_inc = (edges_q == 5'h1F) ? edges_q : edges_q + 5'h01;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_q <= 16'h0000;
            edges_q <= 5'h00;
            echo_q  <= 15'h0000;
            chain_q <= 1'b0;
        end else if (sync_n_s) begin
            edges_q <= 5'h00;
            chain_q <= 1'b0;
        end else if (take_bit) begin
            if (edges_q < dac_cmd_pkg::FULL_EDGES)
                shift_q <= {shift_q[14:0], din_s};
            echo_q  <= {echo_q[13:0], din_s};
            edges_q <= edges_inc;
            if (edges_inc < dac_cmd_pkg::CHAIN_HIGH)
                chain_q <= 1'b0;
            else if (edges_inc == dac_cmd_pkg::CHAIN_HIGH)
                chain_q <= 1'b1;
            else
                // Oldest held bit: bit one leaves on the sixteenth edge
                chain_q <= echo_q[14];
        end
    end
    assign chain_out = chain_q;

    // Frame valid once 15 edges seen; shorter frames are discarded
    wire exec = frame_end & (edges_q > dac_cmd_pkg::ABORT_EDGES);
    wire [3:0] cmd  = shift_q[15:12];
    wire [2:0] chan = shift_q[14:12];
    wire [7:0] code = shift_q[11:4];
    wire [7:0] sel  = shift_q[7:0];

    logic         wt_q;
    logic [7:0]   reg_q [N];
    logic [7:0]   out_q [N];
    logic [N-1:0] pd_q;
    dac_cmd_pkg::term_t term_q;

    wire is_data  = exec & ~shift_q[15];
    wire is_upd   = exec & (cmd == dac_cmd_pkg::CMD_UPD_SEL);
    wire is_cha   = exec & (cmd == dac_cmd_pkg::CMD_CHA_WR);
    wire is_bcast = exec & (cmd == dac_cmd_pkg::CMD_BCAST);
    wire is_pd    = exec & (cmd >= dac_cmd_pkg::CMD_PD_HIZ);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) wt_q <= 1'b0;
        else if (exec && cmd == dac_cmd_pkg::CMD_WR_THRU) wt_q <= 1'b1;
        else if (exec && cmd == dac_cmd_pkg::CMD_REG_ONLY) wt_q <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) term_q <= dac_cmd_pkg::TERM_HIZ;
        else if (is_pd) begin
            unique case (cmd[1:0])
                2'b01:   term_q <= dac_cmd_pkg::TERM_HIZ;
                2'b10:   term_q <= dac_cmd_pkg::TERM_100K;
                default: term_q <= dac_cmd_pkg::TERM_2K5;
            endcase
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_ch
            wire hit_data = is_data & (chan == 3'(g));
            // Register load: channel write, channel-A write, broadcast
            wire ld_reg = hit_data | is_bcast | (is_cha & (g == 0));
            wire [7:0] reg_d = ld_reg ? code : reg_q[g];
            // Output load: same new register value, copied together
            wire ld_out = (hit_data & wt_q) | (is_upd & sel[g]) | is_cha | is_bcast;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    reg_q[g] <= dac_cmd_pkg::CODE_RESET;
                    out_q[g] <= dac_cmd_pkg::CODE_RESET;
                    pd_q[g]  <= 1'b0;
                end else begin
                    reg_q[g] <= reg_d;
                    if (ld_out) out_q[g] <= reg_d;
                    if (is_pd && sel[g]) pd_q[g] <= 1'b1;
                    else if (ld_out) pd_q[g] <= 1'b0;
                end
            end
            assign out_code[g*8 +: 8] = out_q[g];
        end
    endgenerate

    assign pd_active          = pd_q;
    assign pd_term            = term_q;
    assign bias_en            = ~&pd_q;
    assign write_through_mode = wt_q;

    // APB read-only status view, zero-wait
    wire acc = psel & penable;
    wire hit_mode = paddr == dac_cmd_pkg::ADDR_MODE;
    wire hit_pd   = paddr == dac_cmd_pkg::ADDR_PD;
    wire hit_stat = paddr == dac_cmd_pkg::ADDR_STAT;
    wire hit_rlo  = paddr == dac_cmd_pkg::ADDR_REG_LO;
    wire hit_rhi  = paddr == dac_cmd_pkg::ADDR_REG_HI;
    wire hit_olo  = paddr == dac_cmd_pkg::ADDR_OUT_LO;
    wire hit_ohi  = paddr == dac_cmd_pkg::ADDR_OUT_HI;
    wire mapped = hit_mode | hit_pd | hit_stat | hit_rlo | hit_rhi | hit_olo | hit_ohi;
    wire [31:0] rd_mux =
        hit_mode ? {31'h0000_0000, wt_q} :
        hit_pd   ? {22'h00_0000, term_q, pd_q} :
        hit_stat ? {27'h000_0000, edges_q} :
        hit_rlo  ? {reg_q[3], reg_q[2], reg_q[1], reg_q[0]} :
        hit_rhi  ? {reg_q[7], reg_q[6], reg_q[5], reg_q[4]} :
        hit_olo  ? {out_q[3], out_q[2], out_q[1], out_q[0]} :
        hit_ohi  ? {out_q[7], out_q[6], out_q[5], out_q[4]} : 32'h0000_0000;

    // Read data captured in the setup cycle; writes are ignored
    // Mode changes only through serial frames, so the host alone owns it
    logic [31:0] prdata_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else begin
            prdata_q <= (psel & ~penable & ~pwrite) ? rd_mux : prdata_q;
        end
    end
    assign prdata  = prdata_q;
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;

    // Frame capture and chain output
    a_abort_nothing: assert property (@(posedge pclk) disable iff (!presetn)
        (frame_end && edges_q <= dac_cmd_pkg::ABORT_EDGES)
        |=> $stable(wt_q) && $stable(pd_q))
        else $error("short frame changed state");
    a_abort_outputs: assert property (@(posedge pclk) disable iff (!presetn)
        (frame_end && edges_q <= dac_cmd_pkg::ABORT_EDGES)
        |=> $stable(out_code) && $stable(term_q))
        else $error("short frame changed outputs");
    a_edges_clear: assert property (@(posedge pclk) disable iff (!presetn)
        sync_n_s |=> edges_q == 5'h00)
        else $error("edge count not cleared between frames");
    a_idle_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !frame_end
        |=> $stable(wt_q) && $stable(out_code) && $stable(pd_q) && $stable(term_q))
        else $error("state changed without a frame end");
    a_no_shift_idle: assert property (@(posedge pclk) disable iff (!presetn)
        sync_n_s |=> $stable(shift_q))
        else $error("bits shifted outside a frame");
    a_chain_low: assert property (@(posedge pclk) disable iff (!presetn)
        (edges_q != 5'h00 && edges_q < dac_cmd_pkg::CHAIN_HIGH) |-> !chain_out)
        else $error("chain out high too early");
    a_chain_high: assert property (@(posedge pclk) disable iff (!presetn)
        (edges_q == dac_cmd_pkg::CHAIN_HIGH) |-> chain_out)
        else $error("chain out not raised on fifteenth edge");
    a_chain_idle: assert property (@(posedge pclk) disable iff (!presetn)
        sync_n_s |=> !chain_out)
        else $error("chain out high between frames");

    // Mode and channel commands
    a_mode_wt: assert property (@(posedge pclk) disable iff (!presetn)
        (exec && cmd == dac_cmd_pkg::CMD_WR_THRU) |=> wt_q)
        else $error("write-through not entered");
    a_mode_ro: assert property (@(posedge pclk) disable iff (!presetn)
        (exec && cmd == dac_cmd_pkg::CMD_REG_ONLY) |=> !wt_q)
        else $error("register-only mode not entered");
    a_wt_data_keep: assert property (@(posedge pclk) disable iff (!presetn)
        is_data |=> $stable(wt_q))
        else $error("data write changed mode");
    a_special_keep: assert property (@(posedge pclk) disable iff (!presetn)
        (is_upd || is_cha || is_bcast || is_pd) |=> $stable(wt_q))
        else $error("special command changed mode");
    a_reg_only_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (is_data && !wt_q) |=> $stable(out_code))
        else $error("output moved in register-only mode");
    a_data_reg: assert property (@(posedge pclk) disable iff (!presetn)
        is_data |=> reg_q[$past(chan)] == $past(code))
        else $error("channel register not loaded");
    a_wt_write: assert property (@(posedge pclk) disable iff (!presetn)
        (is_data && wt_q) |=> out_code[$past(chan)*8 +: 8] == $past(code))
        else $error("write-through output not updated");
    a_upd_pick: assert property (@(posedge pclk) disable iff (!presetn)
        (is_upd && sel[0]) |=> out_code[7:0] == $past(reg_q[0]))
        else $error("selected output not updated");
    a_upd_skip: assert property (@(posedge pclk) disable iff (!presetn)
        (is_upd && !sel[7]) |=> $stable(out_code[63:56]))
        else $error("unselected output changed");
    a_cha_out: assert property (@(posedge pclk) disable iff (!presetn)
        is_cha |=> out_code[7:0] == $past(code))
        else $error("channel A output wrong");
    a_cha_others: assert property (@(posedge pclk) disable iff (!presetn)
        is_cha |=> out_code[63:56] == $past(reg_q[7]))
        else $error("other channel not copied on channel-A write");
    a_cha_mode: assert property (@(posedge pclk) disable iff (!presetn)
        (is_cha && !wt_q) |=> !wt_q)
        else $error("channel-A write left register-only mode");
    a_bcast_all: assert property (@(posedge pclk) disable iff (!presetn)
        is_bcast |=> out_code[63:56] == $past(code) && out_code[7:0] == $past(code))
        else $error("broadcast missed a channel");
    a_bcast_regs: assert property (@(posedge pclk) disable iff (!presetn)
        is_bcast |=> reg_q[3] == $past(code) && reg_q[4] == $past(code))
        else $error("broadcast missed a register");

    // Power-down, bias and reset state
    a_pd_select: assert property (@(posedge pclk) disable iff (!presetn)
        is_pd |=> pd_active == ($past(pd_q) | $past(sel)))
        else $error("power-down selection wrong");
    a_term_hiz: assert property (@(posedge pclk) disable iff (!presetn)
        (exec && cmd == dac_cmd_pkg::CMD_PD_HIZ) |=> pd_term == dac_cmd_pkg::TERM_HIZ)
        else $error("high-impedance termination not selected");
    a_term_100k: assert property (@(posedge pclk) disable iff (!presetn)
        (exec && cmd == dac_cmd_pkg::CMD_PD_100K) |=> pd_term == dac_cmd_pkg::TERM_100K)
        else $error("100k termination not selected");
    a_term_2k5: assert property (@(posedge pclk) disable iff (!presetn)
        (exec && cmd == dac_cmd_pkg::CMD_PD_2K5) |=> pd_term == dac_cmd_pkg::TERM_2K5)
        else $error("2.5k termination not selected");
    a_term_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (exec && !is_pd) |=> $stable(term_q))
        else $error("termination changed by another command");
    a_pd_regs: assert property (@(posedge pclk) disable iff (!presetn)
        is_pd |=> reg_q[0] == $past(reg_q[0]) && reg_q[7] == $past(reg_q[7]))
        else $error("power-down altered register");
    a_pd_regs_mid: assert property (@(posedge pclk) disable iff (!presetn)
        is_pd |=> reg_q[4] == $past(reg_q[4]))
        else $error("power-down altered middle register");
    a_pd_wake: assert property (@(posedge pclk) disable iff (!presetn)
        is_bcast |=> pd_active == 8'h00)
        else $error("broadcast left a channel powered down");
    a_bias_rule: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(bias_en) |-> $past(is_pd))
        else $error("bias dropped without a power-down command");
    a_reset_clear: assert property (@(posedge pclk)
        !presetn |=> out_code == 64'h0000_0000_0000_0000 && !write_through_mode)
        else $error("reset state not cleared");
endmodule

// ### dac_cmd_pkg.sv
// Package: frame layout, command codes, register map and state types
package dac_cmd_pkg;
    localparam int          FRAME_BITS   = 16;
    localparam int          NUM_CH       = 8;
    localparam logic [4:0]  ABORT_EDGES  = 5'h0E;
    localparam logic [4:0]  FULL_EDGES   = 5'h10;
    localparam logic [4:0]  CHAIN_HIGH   = 5'h0F;
    localparam logic [3:0]  CMD_REG_ONLY = 4'h8;
    localparam logic [3:0]  CMD_WR_THRU  = 4'h9;
    localparam logic [3:0]  CMD_UPD_SEL  = 4'hA;
    localparam logic [3:0]  CMD_CHA_WR   = 4'hB;
    localparam logic [3:0]  CMD_BCAST    = 4'hC;
    localparam logic [3:0]  CMD_PD_HIZ   = 4'hD;
    localparam logic [3:0]  CMD_PD_100K  = 4'hE;
    localparam logic [3:0]  CMD_PD_2K5   = 4'hF;
    localparam logic [7:0]  CODE_RESET   = 8'h00;
    localparam logic [11:0] ADDR_MODE    = 12'h000;
    localparam logic [11:0] ADDR_PD      = 12'h004;
    localparam logic [11:0] ADDR_STAT    = 12'h008;
    localparam logic [11:0] ADDR_REG_LO  = 12'h010;
    localparam logic [11:0] ADDR_REG_HI  = 12'h014;
    localparam logic [11:0] ADDR_OUT_LO  = 12'h018;
    localparam logic [11:0] ADDR_OUT_HI  = 12'h01C;

    typedef enum logic [1:0] {
        TERM_HIZ,
        TERM_100K,
        TERM_2K5
    } term_t;

    typedef struct packed {
        logic       sclk;
        logic       sync_n;
        logic       din;
    } serial_in_t;
endpackage

// ### dac_host_model.sv
// Host serial write controller model that frames commands into the decoder
`timescale 1ns/1ps
module dac_host_model (
    input  wire logic               pclk,
    input  wire logic               chain_out,
    output dac_cmd_pkg::serial_in_t ser_in
);
    logic [31:0] chain_seen;

    initial begin
        ser_in = '{sclk: 1'b1, sync_n: 1'b1, din: 1'b0};
        chain_seen = '0;
    end

    // Sends the first n bits of f, 8 pclk per serial clock period; clock idles still
    task automatic send(input logic [31:0] f, input int n);
        @(posedge pclk);
        ser_in.sync_n <= 1'b0;
        repeat (4) @(posedge pclk);
        for (int k = 0; k < n; k++) begin
            ser_in.din <= f[31-k];
            repeat (4) @(posedge pclk);
            chain_seen[k] = chain_out;
            ser_in.sclk <= 1'b0;
            repeat (4) @(posedge pclk);
            ser_in.sclk <= 1'b1;
        end
        repeat (4) @(posedge pclk);
        ser_in.sync_n <= 1'b1;
        ser_in.din    <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask
endmodule

// ### test_octal_dac_command_decoder.sv
// Self-checking bench for the serial command decoder against a reference model
`timescale 1ns/1ps
module test_octal_dac_command_decoder;
    logic                    pclk;
    logic                    presetn;
    logic                    psel;
    logic                    penable;
    logic                    pwrite;
    logic [11:0]             paddr;
    logic [31:0]             pwdata;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    dac_cmd_pkg::serial_in_t ser_in;
    logic                    chain_out;
    logic [63:0]             out_code;
    logic [7:0]              pd_active;
    dac_cmd_pkg::term_t      pd_term;
    logic                    bias_en;
    logic                    write_through_mode;
    logic [7:0]              reg_m [8];
    logic [7:0]              out_m [8];
    logic [7:0]              pd_m;
    logic [1:0]              term_m;
    logic                    wt_m;
    logic [15:0]             f;
    logic [15:0]             rev;
    logic [31:0]             d;
    logic                    err;
    int                      n;
    int                      num_errors;
    int                      checks_done;
    int                      cycles;

    dac_cmd_decoder u_dac_cmd_decoder (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ser_in(ser_in),
        .chain_out(chain_out), .out_code(out_code), .pd_active(pd_active),
        .pd_term(pd_term), .bias_en(bias_en), .write_through_mode(write_through_mode));
    dac_host_model u_dac_host_model (.pclk(pclk), .chain_out(chain_out), .ser_in(ser_in));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic stop_test();
        if (num_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] w);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= w;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        d   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic model(input logic [15:0] c);
        for (int k = 0; k < 8; k++) begin
            case (c[15:12])
                4'hA: if (c[k]) begin out_m[k] = reg_m[k]; pd_m[k] = 1'b0; end
                4'hB: begin if (k == 0) reg_m[0] = c[11:4]; out_m[k] = reg_m[k]; pd_m[k] = 1'b0; end
                4'hC: begin reg_m[k] = c[11:4]; out_m[k] = c[11:4]; pd_m[k] = 1'b0; end
                4'hD, 4'hE, 4'hF: if (c[k]) pd_m[k] = 1'b1;
                default: if (!c[15] && c[14:12] == k[2:0]) begin
                    reg_m[k] = c[11:4];
                    if (wt_m) begin out_m[k] = c[11:4]; pd_m[k] = 1'b0; end
                end
            endcase
        end
        if (c[15:12] == 4'h8) wt_m = 1'b0;
        if (c[15:12] == 4'h9) wt_m = 1'b1;
        if (c[15:12] >= 4'hD) term_m = 2'(c[15:12] - 4'hD);
    endtask

    task automatic check_all();
        logic [63:0] e;
        for (int k = 0; k < 8; k++) e[k*8+:8] = out_m[k];
        chk(out_code, e);
        chk(64'(pd_active), 64'(pd_m));
        chk(64'(pd_term), 64'(term_m));
        chk(64'(bias_en), 64'(pd_m != 8'hFF));
        chk(64'(write_through_mode), 64'(wt_m));
        apb(1'b0, dac_cmd_pkg::ADDR_REG_LO, 32'h0000_0000);
        chk(64'(d), 64'({reg_m[3], reg_m[2], reg_m[1], reg_m[0]}));
        apb(1'b0, dac_cmd_pkg::ADDR_REG_HI, 32'h0000_0000);
        chk(64'(d), 64'({reg_m[7], reg_m[6], reg_m[5], reg_m[4]}));
        apb(1'b0, dac_cmd_pkg::ADDR_PD, 32'h0000_0000);
        chk(64'(d), 64'({22'h0, term_m, pd_m}));
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        num_errors = 0;
        checks_done = 0;
        cycles = 0;
        wt_m = 1'b0;
        pd_m = '0;
        term_m = '0;
        for (int k = 0; k < 8; k++) begin reg_m[k] = '0; out_m[k] = '0; end
        void'($urandom(37));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        check_all();
        for (int i = 0; i < 96; i++) begin
            f = 16'($urandom);
            if (i < 16) f[15:12] = i[3:0];
            if (i == 16) f = 16'h0FF0;
            if (i == 18) f[15:12] = 4'hF;
            if (i % 24 == 20) f = 16'hD0FF;
            n = (i % 8 == 7) ? 14 : ((i % 8 == 3) ? 32 : 16);
            u_dac_host_model.send({f, 16'($urandom)}, n);
            if (n != 14) begin
                model(f);
                chk(64'(u_dac_host_model.chain_seen[15:1]), 64'h4000);
            end
            if (n == 32) begin
                rev = {<<{f}};
                chk(64'(u_dac_host_model.chain_seen[31:16]), 64'(rev));
            end
            check_all();
        end
        apb(1'b1, dac_cmd_pkg::ADDR_MODE, $urandom);
        apb(1'b0, dac_cmd_pkg::ADDR_MODE, 32'h0000_0000);
        chk(64'(d[0]), 64'(wt_m));
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk(64'({err, d}), 64'h1_0000_0000);
        stop_test();
    end
endmodule
